/* inc/msar_pkg.sv */
// Package with offsets, reset values and serial-link constants of the setpoint register bank
`default_nettype none
package msar_pkg;
	// Holding register addresses and the address unlock key value
	localparam logic [15:0] ADDR_C1    = 16'h0000;
	localparam logic [15:0] ADDR_C2    = 16'h0001;
	localparam logic [15:0] ADDR_F1    = 16'h0002;
	localparam logic [15:0] ADDR_F2    = 16'h0003;
	localparam logic [15:0] ADDR_KEY   = 16'h0004;
	localparam logic [15:0] ADDR_SLAVE = 16'h0005;
	localparam logic [15:0] UNLOCK_KEY = 16'h55AA;
	// Reset values and slave address range
	localparam logic [15:0] RST_CELSIUS    = 16'h0000;
	localparam logic [15:0] RST_FAHRENHEIT = 16'h0020;
	localparam logic [15:0] RST_KEY        = 16'h0000;
	localparam logic [7:0]  RST_SLAVE      = 8'h02;
	localparam logic [7:0]  SLAVE_MIN      = 8'h01;
	localparam logic [7:0]  SLAVE_MAX      = 8'hF7;
	// Temperature conversion constants
	localparam int          FAHR_OFFSET = 32;
	localparam int          FAHR_NUM    = 9;
	localparam int          FAHR_DEN    = 5;
	// Serial settings
	localparam int          CLK_HZ = 10_000_000;
	localparam logic [2:0]  BAUD_300   = 3'h0;
	localparam logic [2:0]  BAUD_1200  = 3'h1;
	localparam logic [2:0]  BAUD_2400  = 3'h2;
	localparam logic [2:0]  BAUD_4800  = 3'h3;
	localparam logic [2:0]  BAUD_9600  = 3'h4;
	localparam logic [2:0]  BAUD_19200 = 3'h5;
	localparam logic [2:0]  BAUD_38400 = 3'h6;
	localparam logic [1:0]  PAR_NONE   = 2'h0;
	localparam logic [1:0]  PAR_EVEN   = 2'h1;
	localparam logic [1:0]  PAR_ODD    = 2'h2;
	localparam int          DATA_BITS  = 8;
	// Byte assembly states
	typedef enum logic [0:0] {
		MSAR_WAIT_MSB = 1'b0,
		MSAR_WAIT_LSB = 1'b1
	} msar_state_t;
endpackage : msar_pkg
`default_nettype wire

/* rtl/msar_regs.sv */
// Holding register write handling, slave address change and serial settings
`default_nettype none
// Functional notes
// - Each register is 16 bits and its write data arrives as the high byte then the low byte.
// - Writing channel one Celsius stores it and sets channel one Fahrenheit to its conversion.
// - Writing channel two Celsius stores it and sets channel two Fahrenheit to its conversion.
// - Writing channel one Fahrenheit stores it and sets channel one Celsius to its conversion.
// - Writing channel two Fahrenheit stores it and sets channel two Celsius to its conversion.
// - Writing the key 0x55AA to the key register unlocks the slave address for change.
// - While unlocked, a write of 1 through 247 to the slave address register gives the device its new address.
// - The reply to that write goes out under the old address; the new one applies afterwards.
// - Once the address has changed the key register returns to zero, relocking the change.
// - The slave address defaults to 2 and stays within 1 through 247.
// - The link runs at one of seven rates from 300 to 38400 baud, 9600 by default.
// - Characters carry 8 data bits, parity none, even or odd, and two stop bits only without parity.
module msar_regs (
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	input  wire logic        hr_byte_valid,
	input  wire logic        hr_byte_first,
	input  wire logic [7:0]  hr_byte,
	input  wire logic [15:0] hr_addr,
	input  wire logic        resp_sent,
	input  wire logic [2:0]  baud_sel,
	input  wire logic [1:0]  parity_sel,
	input  wire logic        two_stop,
	output logic [15:0]      chan1_setpoint_celsius,
	output logic [15:0]      chan2_setpoint_celsius,
	output logic [15:0]      chan1_setpoint_fahrenheit,
	output logic [15:0]      chan2_setpoint_fahrenheit,
	output logic [7:0]       slave_address,
	output logic             addr_unlocked,
	output logic             addr_change_pending,
	output logic             write_done,
	output logic [15:0]      bit_period_cycles,
	output logic             serial_cfg_ok
);
	typedef struct packed {
		msar_pkg::msar_state_t st;
		logic [15:0]           hold_addr;
		logic [7:0]            hold_msb;
		logic [15:0]           c1;
		logic [15:0]           c2;
		logic [15:0]           f1;
		logic [15:0]           f2;
		logic [15:0]           key;
		logic [7:0]            slave;
		logic [7:0]            pend_addr;
		logic                  pend;
		logic                  done;
		logic [15:0]           period;
		logic                  cfg_ok;
	} msar_regs_t;

	msar_regs_t r;
	msar_regs_t next_r;
	logic       wr_commit;
	logic [15:0] wr_word;
	logic       slave_ok;
	logic       pend_set;

	// Celsius to Fahrenheit, integer degrees, quotient truncated toward zero before the offset is added
	function automatic logic [15:0] msar_c2f(input logic [15:0] c);
		int t;
		t = (int'($signed(c)) * msar_pkg::FAHR_NUM) / msar_pkg::FAHR_DEN + msar_pkg::FAHR_OFFSET;
		return t[15:0];
	endfunction : msar_c2f

	// Fahrenheit to Celsius, integer degrees, truncated toward zero
	function automatic logic [15:0] msar_f2c(input logic [15:0] f);
		int t;
		t = ((int'($signed(f)) - msar_pkg::FAHR_OFFSET) * msar_pkg::FAHR_DEN) / msar_pkg::FAHR_NUM;
		return t[15:0];
	endfunction : msar_f2c

	// Bit period in system clocks for the selected rate; unknown codes fall back to 9600
	function automatic logic [15:0] msar_period(input logic [2:0] sel);
		int baud;
		case (sel)
			msar_pkg::BAUD_300:   baud = 300;
			msar_pkg::BAUD_1200:  baud = 1200;
			msar_pkg::BAUD_2400:  baud = 2400;
			msar_pkg::BAUD_4800:  baud = 4800;
			msar_pkg::BAUD_19200: baud = 19200;
			msar_pkg::BAUD_38400: baud = 38400;
			default:              baud = 9600;
		endcase
		return 16'((msar_pkg::CLK_HZ + baud - 1) / baud);
	endfunction : msar_period

	// A register write completes on its second byte, high byte already held
	assign wr_commit = hr_byte_valid && !hr_byte_first && (r.st == msar_pkg::MSAR_WAIT_LSB);
	assign wr_word   = {r.hold_msb, hr_byte};
	assign slave_ok  = (wr_word[15:8] == 8'h00) && (wr_word[7:0] >= msar_pkg::SLAVE_MIN)
		&& (wr_word[7:0] <= msar_pkg::SLAVE_MAX);
	// An accepted address write this cycle, so a same-cycle switch cannot swallow it
	assign pend_set  = wr_commit && (r.hold_addr == msar_pkg::ADDR_SLAVE)
		&& (r.key == msar_pkg::UNLOCK_KEY) && slave_ok;

	// Next-state logic for the whole bank
	always_comb begin
		next_r      = r;
		next_r.done = 1'b0;
		// Byte pairing: a first-flagged byte always restarts, so a lost low byte cannot skew pairs
		if (hr_byte_valid && hr_byte_first) begin
			next_r.st        = msar_pkg::MSAR_WAIT_LSB;
			next_r.hold_msb  = hr_byte;
			next_r.hold_addr = hr_addr;
		end else if (wr_commit) begin
			next_r.st   = msar_pkg::MSAR_WAIT_MSB;
			next_r.done = 1'b1;
			case (r.hold_addr)
				msar_pkg::ADDR_C1: begin
					next_r.c1 = wr_word;
					next_r.f1 = msar_c2f(wr_word);
				end
				msar_pkg::ADDR_C2: begin
					next_r.c2 = wr_word;
					next_r.f2 = msar_c2f(wr_word);
				end
				msar_pkg::ADDR_F1: begin
					next_r.f1 = wr_word;
					next_r.c1 = msar_f2c(wr_word);
				end
				msar_pkg::ADDR_F2: begin
					next_r.f2 = wr_word;
					next_r.c2 = msar_f2c(wr_word);
				end
				msar_pkg::ADDR_KEY: begin
					next_r.key = wr_word;
				end
				msar_pkg::ADDR_SLAVE: begin
					// Held until the reply is out, so the reply still matches the old address
					if ((r.key == msar_pkg::UNLOCK_KEY) && slave_ok) begin
						next_r.pend_addr = wr_word[7:0];
						next_r.pend      = 1'b1;
					end
				end
				default: begin
				end
			endcase
		end
		// Switch address only after the response has left
		if (r.pend && resp_sent) begin
			next_r.slave = r.pend_addr;
			next_r.pend  = pend_set;  // A change taken this cycle outranks the clear
			next_r.key   = msar_pkg::RST_KEY;
		end
		// Serial settings registered so outputs come from flops
		next_r.period = msar_period(baud_sel);
		next_r.cfg_ok = (baud_sel <= msar_pkg::BAUD_38400)
			&& (parity_sel != 2'h3)
			&& !(two_stop && (parity_sel != msar_pkg::PAR_NONE));
	end

	// State register with synchronous reset
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			r           <= '0;
			r.st        <= msar_pkg::MSAR_WAIT_MSB;
			r.c1        <= msar_pkg::RST_CELSIUS;
			r.c2        <= msar_pkg::RST_CELSIUS;
			r.f1        <= msar_pkg::RST_FAHRENHEIT;
			r.f2        <= msar_pkg::RST_FAHRENHEIT;
			r.key       <= msar_pkg::RST_KEY;
			r.slave     <= msar_pkg::RST_SLAVE;
			r.pend_addr <= msar_pkg::RST_SLAVE;
			r.period    <= msar_period(msar_pkg::BAUD_9600);
		end else begin
			r <= next_r;
		end
	end

	// Outputs straight from the state register, except addr_unlocked, which is decoded from the held key
	assign chan1_setpoint_celsius    = r.c1;
	assign chan2_setpoint_celsius    = r.c2;
	assign chan1_setpoint_fahrenheit = r.f1;
	assign chan2_setpoint_fahrenheit = r.f2;
	assign slave_address             = r.slave;
	assign addr_unlocked             = (r.key == msar_pkg::UNLOCK_KEY);
	assign addr_change_pending       = r.pend;
	assign write_done                = r.done;
	assign bit_period_cycles         = r.period;
	assign serial_cfg_ok             = r.cfg_ok;

	property p_c1_write;
		@(posedge clk_sys) disable iff (!rst_n)
		wr_commit && r.hold_addr == msar_pkg::ADDR_C1 && !hr_byte_first
		|=> r.c1 == $past(wr_word) && r.f1 == msar_c2f($past(wr_word));
	endproperty
	a_c1_write: assert property (p_c1_write) else $error("c1 write bad");

	property p_c2_write;
		@(posedge clk_sys) disable iff (!rst_n)
		wr_commit && r.hold_addr == msar_pkg::ADDR_C2
		|=> r.c2 == $past(wr_word) && r.f2 == msar_c2f(r.c2);
	endproperty
	a_c2_write: assert property (p_c2_write) else $error("c2 write bad");

	property p_f1_write;
		@(posedge clk_sys) disable iff (!rst_n)
		wr_commit && r.hold_addr == msar_pkg::ADDR_F1
		|=> r.f1 == $past(wr_word) && r.c1 == msar_f2c(r.f1);
	endproperty
	a_f1_write: assert property (p_f1_write) else $error("f1 write bad");

	property p_f2_write;
		@(posedge clk_sys) disable iff (!rst_n)
		wr_commit && r.hold_addr == msar_pkg::ADDR_F2
		|=> r.f2 == $past(wr_word) && r.c2 == msar_f2c(r.f2);
	endproperty
	a_f2_write: assert property (p_f2_write) else $error("f2 write bad");

	property p_unlock;
		@(posedge clk_sys) disable iff (!rst_n)
		wr_commit && r.hold_addr == msar_pkg::ADDR_KEY && wr_word == msar_pkg::UNLOCK_KEY
		&& !(r.pend && resp_sent) |=> addr_unlocked;
	endproperty
	a_unlock: assert property (p_unlock) else $error("key write did not unlock");

	property p_addr_change;
		@(posedge clk_sys) disable iff (!rst_n)
		r.pend && resp_sent |=> slave_address == $past(r.pend_addr) && !addr_unlocked;
	endproperty
	a_addr_change: assert property (p_addr_change) else $error("address not adopted");

	property p_old_addr_kept;
		@(posedge clk_sys) disable iff (!rst_n)
		!resp_sent |=> $stable(slave_address);
	endproperty
	a_old_addr_kept: assert property (p_old_addr_kept) else $error("address moved early");

	property p_relock;
		@(posedge clk_sys) disable iff (!rst_n)
		$changed(slave_address) |-> r.key == msar_pkg::RST_KEY;
	endproperty
	a_relock: assert property (p_relock) else $error("key not cleared");

	property p_addr_range;
		@(posedge clk_sys) disable iff (!rst_n)
		slave_address >= msar_pkg::SLAVE_MIN && slave_address <= msar_pkg::SLAVE_MAX;
	endproperty
	a_addr_range: assert property (p_addr_range) else $error("address out of range");

	property p_locked_write;
		@(posedge clk_sys) disable iff (!rst_n)
		wr_commit && r.hold_addr == msar_pkg::ADDR_SLAVE && (!addr_unlocked || !slave_ok)
		&& !r.pend |=> !r.pend;
	endproperty
	a_locked_write: assert property (p_locked_write) else $error("bad address write taken");

	property p_stop_bits;
		@(posedge clk_sys) disable iff (!rst_n)
		two_stop && parity_sel != msar_pkg::PAR_NONE |=> !serial_cfg_ok;
	endproperty
	a_stop_bits: assert property (p_stop_bits) else $error("two stop with parity accepted");
endmodule : msar_regs
`default_nettype wire

/* test/modbus_setpoint_and_address_regs_tb.sv */
// Self-checking bench for the setpoint and address register bank
`default_nettype none
module modbus_setpoint_and_address_regs_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys = 1'b0, rst_n = 1'b0, req = 1'b0, resp_sent = 1'b0, two_stop = 1'b0;
	logic [15:0] req_addr = 16'h0000, req_data = 16'h0000;
	logic [2:0] baud_sel = 3'h4;
	logic [1:0] parity_sel = 2'h0;
	logic v, f, unl, pend, done, ok;
	logic [7:0] b, slv;
	logic [15:0] a, c1, c2, f1, f2, per;
	int n_mismatch = 0, n_compared = 0, cycles = 0;
	int rates [7] = '{300, 1200, 2400, 4800, 9600, 19200, 38400};
	always #50 clk_sys = ~clk_sys;
	msar_master_model i_master (.clk_sys(clk_sys), .rst_n(rst_n), .req(req), .req_addr(req_addr),
		.req_data(req_data), .hr_byte_valid(v), .hr_byte_first(f), .hr_byte(b), .hr_addr(a));
	msar_regs i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .hr_byte_valid(v), .hr_byte_first(f),
		.hr_byte(b), .hr_addr(a), .resp_sent(resp_sent), .baud_sel(baud_sel),
		.parity_sel(parity_sel), .two_stop(two_stop), .chan1_setpoint_celsius(c1),
		.chan2_setpoint_celsius(c2), .chan1_setpoint_fahrenheit(f1),
		.chan2_setpoint_fahrenheit(f2), .slave_address(slv), .addr_unlocked(unl),
		.addr_change_pending(pend), .write_done(done), .bit_period_cycles(per),
		.serial_cfg_ok(ok));
	task automatic conclude();
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : conclude
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// Hand one write to the master and wait, bounded, for the completion pulse
	task automatic wr(input logic [15:0] ad, input logic [15:0] d);
		int i;
		@(posedge clk_sys);
		req      <= 1'b1;
		req_addr <= ad;
		req_data <= d;
		@(posedge clk_sys);
		req <= 1'b0;
		for (i = 0; i < 10; i++) begin
			@(posedge clk_sys);
			#1;
			if (done === 1'b1)
				break;
		end
		chk(16'(done), 16'h0001);
	endtask : wr
	// Reference conversions, signed degrees, each quotient truncated toward zero
	function automatic logic [15:0] to_f(input logic [15:0] c);
		int t;
		t = int'($signed(c));
		return 16'(t * 9 / 5 + 32);
	endfunction : to_f
	function automatic logic [15:0] to_c(input logic [15:0] x);
		int t;
		t = int'($signed(x));
		return 16'((t - 32) * 5 / 9);
	endfunction : to_c
	// Hang guard, generous for some 100 cycles of real work
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 3000) begin
			n_mismatch++;
			conclude();
		end
	end
	initial begin
		repeat (4) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		#1;
		// Values left by reset, serial settings already following the inputs
		chk(16'(slv), 16'h0002);
		chk(16'(unl), 16'h0000);
		chk(16'(pend), 16'h0000);
		chk(16'(done), 16'h0000);
		chk(c1, msar_pkg::RST_CELSIUS);
		chk(f2, msar_pkg::RST_FAHRENHEIT);
		chk(per, 16'((msar_pkg::CLK_HZ + 9600 - 1) / 9600));
		chk(16'(ok), 16'h0001);
		wr(16'h0000, 16'h0064);
		chk(c1, 16'h0064);
		chk(f1, to_f(16'h0064));
		wr(16'h0001, 16'hFFD8);
		chk(c2, 16'hFFD8);
		chk(f2, to_f(16'hFFD8));
		wr(16'h0002, 16'h0050);
		chk(f1, 16'h0050);
		chk(c1, to_c(16'h0050));
		wr(16'h0003, 16'h0032);
		chk(f2, 16'h0032);
		chk(c2, to_c(16'h0032));
		// An unmapped write completes but must disturb no setpoint
		wr(16'h0009, 16'h1234);
		chk(c1, to_c(16'h0050));
		chk(f2, 16'h0032);
		wr(16'h0005, 16'h0007);
		chk(16'(slv), 16'h0002);
		wr(16'h0004, 16'h55AB);
		chk(16'(unl), 16'h0000);
		wr(16'h0004, 16'h55AA);
		chk(16'(unl), 16'h0001);
		wr(16'h0005, 16'h00F8);
		chk(16'(pend), 16'h0000);
		wr(16'h0005, 16'h00F7);
		chk(16'(pend), 16'h0001);
		chk(16'(slv), 16'h0002);
		@(posedge clk_sys);
		resp_sent <= 1'b1;
		@(posedge clk_sys);
		resp_sent <= 1'b0;
		@(posedge clk_sys);
		#1;
		chk(16'(slv), 16'h00F7);
		chk(16'(unl), 16'h0000);
		chk(16'(pend), 16'h0000);
		wr(16'h0005, 16'h0003);
		chk(16'(slv), 16'h00F7);
		// Every rate code, then the parity and stop-bit pairings
		for (int k = 0; k < 7; k++) begin
			@(posedge clk_sys);
			baud_sel <= 3'(k);
			repeat (2) @(posedge clk_sys);
			#1;
			chk(per, 16'((msar_pkg::CLK_HZ + rates[k] - 1) / rates[k]));
		end
		for (int k = 0; k < 6; k++) begin
			@(posedge clk_sys);
			parity_sel <= 2'(k % 3);
			two_stop   <= k[0];
			repeat (2) @(posedge clk_sys);
			#1;
			chk(16'(ok), 16'((k % 3 == 0) || !k[0]));
		end
		// Unused rate code: period falls back to the default rate and the setting is refused
		@(posedge clk_sys);
		baud_sel   <= 3'h7;
		parity_sel <= 2'h0;
		two_stop   <= 1'b0;
		repeat (2) @(posedge clk_sys);
		#1;
		chk(per, 16'((msar_pkg::CLK_HZ + 9600 - 1) / 9600));
		chk(16'(ok), 16'h0000);
		// Unused parity code is refused on an otherwise valid rate
		@(posedge clk_sys);
		baud_sel   <= 3'h4;
		parity_sel <= 2'h3;
		repeat (2) @(posedge clk_sys);
		#1;
		chk(16'(ok), 16'h0000);
		conclude();
	end
endmodule : modbus_setpoint_and_address_regs_tb
`default_nettype wire

/* test/msar_master_model.sv */
// Master stand-in that sends each holding register write as a byte pair
`default_nettype none
module msar_master_model (
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	input  wire logic        req,
	input  wire logic [15:0] req_addr,
	input  wire logic [15:0] req_data,
	output logic             hr_byte_valid,
	output logic             hr_byte_first,
	output logic [7:0]       hr_byte,
	output logic [15:0]      hr_addr
);
	timeunit 1ns;
	timeprecision 1ns;
	logic second;
	// Idle lines toggle every cycle so that stale data can never be mistaken for a byte
	always @(posedge clk_sys) begin
		hr_byte_valid <= 1'b0;
		hr_byte_first <= 1'b0;
		hr_byte       <= ~hr_byte;
		hr_addr       <= ~hr_addr;
		second        <= 1'b0;
		if (!rst_n) begin
			hr_byte <= 8'h00;
			hr_addr <= 16'h0000;
		end else if (second) begin
			hr_byte_valid <= 1'b1;
			hr_byte       <= req_data[7:0];
		end else if (req) begin
			hr_byte_valid <= 1'b1;
			hr_byte_first <= 1'b1;
			hr_byte       <= req_data[15:8];
			hr_addr       <= req_addr;
			second        <= 1'b1;
		end
	end
endmodule : msar_master_model
`default_nettype wire
